//--- include/alc_map.svh
`ifndef ALC_MAP_SVH
`define ALC_MAP_SVH

// Register indices; byte address is four times the index
`define IDX_HOLD_CFG    8'h21
`define IDX_GATE_CFG    8'h23
`define IDX_CTRL        8'h30
`define IDX_STATUS      8'h31

// Field positions
`define HOLD_LSB        4
`define HOLD_MSB        7
`define GATE_THR_MSB    2
`define GATE_EN_BIT     3

// Reset values
`define HOLD_RST        4'h0
`define GATE_RST        4'h0
`define CEIL_RST        3'h7
`define FLOOR_RST       3'h0
`define MANUAL_RST      6'h10

// Timing, in audio sample periods (48 kHz assumed)
`define HOLD_BASE_US    2670
`define SAMPLE_NS       20833
// Nearest, not up: a spare base sample doubles with every code
`define HOLD_BASE_SMP   ((`HOLD_BASE_US * 1000 + `SAMPLE_NS / 2) / `SAMPLE_NS)
`define HOLD_MAX_CODE   4'hA
`define DECAY_SHIFT     2

// Level figures
`define PEAK_LIMIT      16'h7000
`define GATE_TOP_QDB    (-156)
`define GATE_STEP_QDB   24
`define GAIN_BASE_QDB   (-48)
`define GAIN_STEP_QDB   3
`endif

//--- include/alc_pkg.sv
package alc_pkg;
  typedef enum logic [4:0] {
    ST_OFF    = 5'h01,
    ST_ATTACK = 5'h02,
    ST_HOLD   = 5'h04,
    ST_DECAY  = 5'h08,
    ST_GATED  = 5'h10
  } alc_state_t;

  typedef struct packed {
    logic [5:0] manual_gain;
    logic [2:0] floor_code;
    logic [2:0] ceil_code;
    logic [3:0] decay_code;
    logic [3:0] attack_code;
    logic       mode_limiter;
    logic       enable;
  } ctrl_t;

  typedef struct packed {
    logic [3:0] hold_code;
  } hold_cfg_t;

  typedef struct packed {
    logic       gate_on;
    logic [2:0] thr_code;
  } gate_cfg_t;
endpackage

//--- design/sample_timer.sv
`timescale 1ns/10ps
module sample_timer (
  input  wire logic        mclk_i,
  input  wire logic        srst_i,
  input  wire logic        tick_i,
  input  wire logic        restart_i,
  input  wire logic [16:0] len_i,
  output logic             done_o
);
  logic [16:0] count_q;

  // Saturates at the length so a long stall cannot wrap
  always_ff @(posedge mclk_i) begin
    if (srst_i || restart_i) begin
      count_q <= 17'h00000;
    end else if (tick_i && !done_o) begin
      count_q <= count_q + 17'h00001;
    end
  end

  assign done_o = (count_q >= len_i);
endmodule // sample_timer

//--- design/alc_hold_gate.sv
`timescale 1ns/10ps
`include "alc_map.svh"
module alc_hold_gate (
  input  wire logic               mclk_i,
  input  wire logic               srst_i,
  input  wire logic [9:0]         avs_address_i,
  input  wire logic               avs_read_i,
  input  wire logic               avs_write_i,
  input  wire logic [31:0]        avs_writedata_i,
  output logic [31:0]             avs_readdata_o,
  output logic                    avs_waitrequest_o,
  input  wire logic               sample_tick_i,
  input  wire logic [15:0]        adc_peak_i,
  input  wire logic               above_target_i,
  input  wire logic signed [11:0] level_qdb_i,
  input  wire logic [5:0]         boost_db_i,
  output logic [5:0]              pga_gain_o,
  output logic                    peak_active_o,
  output logic                    gate_active_o
);
  alc_pkg::ctrl_t      ctrl_q;
  alc_pkg::hold_cfg_t  hold_q;
  alc_pkg::gate_cfg_t  gate_q;
  alc_pkg::alc_state_t state_q;
  alc_pkg::alc_state_t state_d;
  logic                ack_q;
  logic [31:0]         rdata_q;
  logic [5:0]          gain_q;
  logic                peak_q;
  logic                gated_q;
  logic [7:0]          idx;
  logic                wr_go;
  logic                peak;
  logic                gated;
  logic                hold_done;
  logic                ramp_done;
  logic                ramp_restart;
  logic                atk_step;
  logic                dcy_step;
  logic [5:0]          floor_idx;
  logic [5:0]          ceil_idx;
  logic signed [12:0]  gate_ref;
  logic [16:0]         hold_len;
  logic [16:0]         ramp_len;

  // Hold length in samples, saturating above the top code
  function automatic logic [16:0] hold_samples(input logic [3:0] code);
    logic [3:0] c;
    c = (code > `HOLD_MAX_CODE) ? `HOLD_MAX_CODE : code;
    if (c == 4'h0) begin
      hold_samples = 17'h00000;
    end else begin
      hold_samples = 17'(`HOLD_BASE_SMP) << (c - 4'h1);
    end
  endfunction

  // Ramp step spacing in samples; shared by attack and decay
  function automatic logic [16:0] rate_samples(input logic [3:0] code);
    logic [3:0] c;
    c = (code > `HOLD_MAX_CODE) ? `HOLD_MAX_CODE : code;
    rate_samples = 17'h00001 << c;
  endfunction

  // Bus slave: one wait cycle, then the answer
  assign idx = avs_address_i[9:2];
  assign avs_waitrequest_o = (avs_read_i || avs_write_i) && !ack_q;
  assign wr_go = avs_write_i && ack_q;

  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= (avs_read_i || avs_write_i) && !ack_q;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      rdata_q <= 32'h00000000;
    end else if (avs_read_i && !ack_q) begin
      unique case (idx)
        `IDX_HOLD_CFG: rdata_q <= {24'h000000, hold_q.hold_code, 4'h0};
        `IDX_GATE_CFG: rdata_q <= {28'h0000000, gate_q};
        `IDX_CTRL:     rdata_q <= {10'h000, ctrl_q};
        `IDX_STATUS:   rdata_q <= {18'h00000, state_q, gated_q, peak_q,
                                   1'b0, gain_q};
        default:       rdata_q <= 32'h00000000;
      endcase
    end
  end
  assign avs_readdata_o = rdata_q;

  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      hold_q.hold_code <= `HOLD_RST;
    end else if (wr_go && idx == `IDX_HOLD_CFG) begin
      hold_q.hold_code <= avs_writedata_i[`HOLD_MSB:`HOLD_LSB];
    end
  end

  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      gate_q <= `GATE_RST;
    end else if (wr_go && idx == `IDX_GATE_CFG) begin
      gate_q <= avs_writedata_i[`GATE_EN_BIT:0];
    end
  end

  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      ctrl_q             <= '0;
      ctrl_q.ceil_code   <= `CEIL_RST;
      ctrl_q.floor_code  <= `FLOOR_RST;
      ctrl_q.manual_gain <= `MANUAL_RST;
    end else if (wr_go && idx == `IDX_CTRL) begin
      ctrl_q <= avs_writedata_i[21:0];
    end
  end

  // Level detection
  assign peak = ctrl_q.enable && (adc_peak_i > `PEAK_LIMIT);
  // Gate reference in quarter dB: threshold + PGA gain + mic boost
  assign gate_ref = 13'(`GATE_TOP_QDB)
                  - 13'(`GATE_STEP_QDB) * $signed({10'h000, gate_q.thr_code})
                  + 13'(`GAIN_BASE_QDB)
                  + 13'(`GAIN_STEP_QDB) * $signed({7'h00, gain_q})
                  + $signed({5'h00, boost_db_i, 2'b00});
  assign gated = gate_q.gate_on && !ctrl_q.mode_limiter
              && (13'(level_qdb_i) < gate_ref);

  // Gain limits as 0.75 dB indices
  assign floor_idx = {ctrl_q.floor_code, 3'b000};
  assign ceil_idx  = {ctrl_q.ceil_code, 3'b111};

  assign hold_len = hold_samples(hold_q.hold_code);
  assign ramp_len = (state_q == alc_pkg::ST_ATTACK)
                  ? rate_samples(ctrl_q.attack_code)
                  : rate_samples(ctrl_q.decay_code) << `DECAY_SHIFT;

  sample_timer u_hold_timer (
    .mclk_i    (mclk_i),
    .srst_i    (srst_i),
    .tick_i    (sample_tick_i),
    .restart_i (state_q != alc_pkg::ST_HOLD),
    .len_i     (hold_len),
    .done_o    (hold_done)
  );

  sample_timer u_ramp_timer (
    .mclk_i    (mclk_i),
    .srst_i    (srst_i),
    .tick_i    (sample_tick_i),
    .restart_i (ramp_restart),
    .len_i     (ramp_len),
    .done_o    (ramp_done)
  );

  // Disable first, then peak or target, then mode-specific behaviour
  always_comb begin
    state_d = state_q;
    if (!ctrl_q.enable) begin
      state_d = alc_pkg::ST_OFF;
    end else if (peak || above_target_i) begin
      state_d = alc_pkg::ST_ATTACK;
    end else if (ctrl_q.mode_limiter) begin
      state_d = alc_pkg::ST_DECAY;
    end else if (gated) begin
      state_d = alc_pkg::ST_GATED;
    end else begin
      unique case (state_q)
        alc_pkg::ST_HOLD:  if (hold_done) begin
          state_d = alc_pkg::ST_DECAY;
        end
        alc_pkg::ST_DECAY: state_d = alc_pkg::ST_DECAY;
        default:           state_d = alc_pkg::ST_HOLD;
      endcase
    end
  end

  // Decisions taken once per sample; disable acts at once
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      state_q <= alc_pkg::ST_OFF;
    end else if (!ctrl_q.enable || sample_tick_i) begin
      state_q <= state_d;
    end
  end

  assign atk_step = sample_tick_i && state_q == alc_pkg::ST_ATTACK
                 && ramp_done;
  assign dcy_step = sample_tick_i && state_q == alc_pkg::ST_DECAY
                 && ramp_done;
  assign ramp_restart = !ctrl_q.enable || atk_step || dcy_step
                     || (sample_tick_i && state_d != state_q);

  // Gain: limits first, then peak step every sample (fastest code)
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      gain_q <= `MANUAL_RST;
    end else if (!ctrl_q.enable) begin
      gain_q <= ctrl_q.manual_gain;
    end else if (gain_q > ceil_idx) begin
      gain_q <= ceil_idx;
    end else if (gain_q < floor_idx) begin
      gain_q <= floor_idx;
    end else if (sample_tick_i && (peak || atk_step)) begin
      if (gain_q > floor_idx) begin
        gain_q <= gain_q - 6'h01;
      end
    end else if (dcy_step && gain_q < ceil_idx) begin
      gain_q <= gain_q + 6'h01;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      peak_q  <= 1'b0;
      gated_q <= 1'b0;
    end else begin
      peak_q  <= peak;
      gated_q <= state_q == alc_pkg::ST_GATED;
    end
  end

  assign pga_gain_o    = gain_q;
  assign peak_active_o = peak_q;
  assign gate_active_o = gated_q;

  a_hold_normal_only: assert property (@(posedge mclk_i)
    disable iff (srst_i)
    state_q == alc_pkg::ST_HOLD |-> !ctrl_q.mode_limiter)
    else $error("hold entered in limiter mode");

  a_hold_reset_val: assert property (@(posedge mclk_i)
    $fell(srst_i) |-> hold_q.hold_code == 4'h0 && gate_q == 4'h0)
    else $error("config not reset to zero");

  a_hold_len_table: assert property (@(posedge mclk_i)
    disable iff (srst_i)
    (hold_q.hold_code == 4'h1 |-> hold_len == 17'h00080)
    and (hold_q.hold_code >= 4'hA |-> hold_len == 17'h10000))
    else $error("hold length wrong");

  a_hold_then_decay: assert property (@(posedge mclk_i)
    disable iff (srst_i)
    state_q == alc_pkg::ST_HOLD && hold_done && sample_tick_i
    && ctrl_q.enable && !peak && !above_target_i && !gated
    |=> state_q == alc_pkg::ST_DECAY)
    else $error("hold expiry did not start decay");

  a_hold_abandon: assert property (@(posedge mclk_i)
    disable iff (srst_i)
    state_q == alc_pkg::ST_HOLD && sample_tick_i && above_target_i
    && ctrl_q.enable |=> state_q == alc_pkg::ST_ATTACK)
    else $error("hold not abandoned");

  a_peak_ramp_down: assert property (@(posedge mclk_i)
    disable iff (srst_i)
    sample_tick_i && peak && gain_q > floor_idx && gain_q <= ceil_idx
    ##1 ctrl_q.enable |-> gain_q == $past(gain_q) - 6'h01)
    else $error("peak did not lower gain");

  a_peak_auto_on: assert property (@(posedge mclk_i)
    disable iff (srst_i)
    (ctrl_q.enable && adc_peak_i > `PEAK_LIMIT |=> peak_active_o)
    and (!ctrl_q.enable |=> !peak_active_o))
    else $error("peak flag does not follow enable");

  a_gate_holds_gain: assert property (@(posedge mclk_i)
    disable iff (srst_i)
    state_q == alc_pkg::ST_GATED && ctrl_q.enable && !peak
    && gain_q >= floor_idx && gain_q <= ceil_idx
    |=> gain_q >= $past(gain_q)-6'h01 && gain_q <= $past(gain_q))
    else $error("gain rose while gated");

  a_gate_mode: assert property (@(posedge mclk_i)
    disable iff (srst_i)
    state_q == alc_pkg::ST_GATED |-> !ctrl_q.mode_limiter && gate_q.gate_on)
    else $error("gate active outside normal mode");

  a_gain_in_range: assert property (@(posedge mclk_i)
    disable iff (srst_i)
    ctrl_q.enable && floor_idx <= ceil_idx ##1 ctrl_q.enable
    && $stable(ctrl_q) |-> gain_q >= floor_idx && gain_q <= ceil_idx)
    else $error("gain outside limits");
endmodule // alc_hold_gate

//--- tb/alc_front_model.sv
`timescale 1ns/10ps
module alc_front_model #(
  parameter int         TICK_DIV = 4,
  parameter logic [5:0] BOOST    = 6'h0C
) (
  input  wire logic               mclk_i,
  input  wire logic               srst_i,
  input  wire logic [15:0]        peak_cmd_i,
  input  wire logic               above_cmd_i,
  input  wire logic signed [11:0] level_cmd_i,
  output logic                    tick_o = 1'b0,
  output logic [15:0]             adc_peak_o = '0,
  output logic                    above_o = 1'b0,
  output logic signed [11:0]      level_o = '0,
  output logic [5:0]              boost_o
);
  int div_q = 0;

  // Measurements move only on a sample, never between them
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      div_q <= 0;
      tick_o <= 1'b0;
    end else begin
      div_q <= (div_q == TICK_DIV - 1) ? 0 : div_q + 1;
      tick_o <= (div_q == TICK_DIV - 1);
    end
  end

  always_ff @(posedge mclk_i) begin
    if (div_q == TICK_DIV - 1) begin
      adc_peak_o <= peak_cmd_i;
      above_o <= above_cmd_i;
      level_o <= level_cmd_i;
    end
  end

  assign boost_o = BOOST;
endmodule  // alc_front_model

//--- tb/alc_hold_peak_limit_noise_gate_tb_top.sv
`timescale 1ns/10ps
`include "alc_map.svh"
module alc_hold_peak_limit_noise_gate_tb_top;
  localparam logic [9:0] adr_hold = {`IDX_HOLD_CFG, 2'b00};
  localparam logic [9:0] adr_gate = {`IDX_GATE_CFG, 2'b00};
  localparam logic [9:0] adr_ctrl = {`IDX_CTRL, 2'b00};
  localparam logic [9:0] adr_stat = {`IDX_STATUS, 2'b00};
  logic               mclk_i = 1'b0;
  logic               srst_i = 1'b1;
  logic [9:0]         adr = '0;
  logic               rd = 1'b0;
  logic               wr = 1'b0;
  logic [31:0]        wdat = '0;
  logic [31:0]        rdat;
  logic               wreq;
  logic               tick;
  logic [15:0]        peak;
  logic               above;
  logic signed [11:0] level;
  logic [5:0]         boost;
  logic [5:0]         gain;
  logic               pk_act;
  logic               gt_act;
  logic [15:0]        peak_cmd = 16'h1000;
  logic               above_cmd = 1'b0;
  logic signed [11:0] level_cmd = '0;
  logic [31:0]        q;
  logic [31:0]        w;
  logic [15:0]        lfsr = 16'h8FEB;
  int                 errors = 0;
  int                 cmp_count = 0;

  always #4 mclk_i = ~mclk_i;

  alc_hold_gate dut_u (.mclk_i(mclk_i), .srst_i(srst_i),
    .avs_address_i(adr), .avs_read_i(rd), .avs_write_i(wr),
    .avs_writedata_i(wdat), .avs_readdata_o(rdat),
    .avs_waitrequest_o(wreq), .sample_tick_i(tick), .adc_peak_i(peak),
    .above_target_i(above), .level_qdb_i(level), .boost_db_i(boost),
    .pga_gain_o(gain), .peak_active_o(pk_act), .gate_active_o(gt_act));

  alc_front_model #(.TICK_DIV(4), .BOOST(6'h0C)) fe_u (.mclk_i(mclk_i),
    .srst_i(srst_i), .peak_cmd_i(peak_cmd), .above_cmd_i(above_cmd),
    .level_cmd_i(level_cmd), .tick_o(tick), .adc_peak_o(peak),
    .above_o(above), .level_o(level), .boost_o(boost));

  // Reference model: hold length in samples, gate level in quarter dB
  function automatic int hold_t(input int c);
    return (c == 0) ? 0 : (c > 10) ? (128 << 9) : (128 << (c - 1));
  endfunction

  function automatic int gate_lvl(input int c, input int g, input int b);
    return 4 * (-39 - 6 * c) + 3 * g - 48 + 4 * b;
  endfunction

  function automatic logic [15:0] rnd();
    lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
    return lfsr;
  endfunction

  function automatic logic [31:0] ctl(input int m, input int a);
    return 32'h00101C01 | (m << 1) | (a << 2);
  endfunction

  task automatic finish_test();
    $display("errors=%0d compares=%0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_pin(input logic [5:0] got, input logic [5:0] exp);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One edge first, so a strobe is never lowered and raised at once
  task automatic bus(input logic wr_i, input logic [9:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge mclk_i);
    adr <= a;
    wdat <= d;
    wr <= wr_i;
    rd <= !wr_i;
    do begin
      @(posedge mclk_i);
      n++;
    end while (wreq !== 1'b0 && n < 50);
    q = rdat;
    wr <= 1'b0;
    rd <= 1'b0;
    if (wreq !== 1'b0) begin
      errors++;
      finish_test();
    end
  endtask

  task automatic ticks(input int k);
    int n;
    n = 0;
    while (k > 0) begin
      @(posedge mclk_i);
      if (tick === 1'b1) k--;
      n++;
      if (n > 5000) begin
        errors++;
        finish_test();
      end
    end
    repeat (2) @(posedge mclk_i);
  endtask

  // Commands back to quiet, so no scenario inherits a peak or a level
  task automatic rst();
    srst_i <= 1'b1;
    peak_cmd <= 16'h1000;
    above_cmd <= 1'b0;
    level_cmd <= '0;
    repeat (5) @(posedge mclk_i);
    srst_i <= 1'b0;
  endtask

  initial begin
    rst();
    bus(1'b0, adr_hold, '0);
    chk_reg(q, 32'h0);
    bus(1'b0, adr_gate, '0);
    chk_reg(q, 32'h0);
    w = {16'h0, rnd()};
    bus(1'b1, adr_hold, w);
    bus(1'b0, adr_hold, '0);
    chk_reg(q, w & 32'hF0);
    w = {16'h0, rnd()};
    bus(1'b1, adr_gate, w);
    bus(1'b0, adr_gate, '0);
    chk_reg(q, w & 32'hF);
    bus(1'b1, 10'h3F0, 32'hFFFF);
    bus(1'b0, 10'h3F0, '0);
    chk_reg(q, 32'h0);
    bus(1'b0, adr_ctrl, '0);
    chk_reg(q, 32'h00101C00);
    $display("end regs");
    rst();
    peak_cmd <= 16'h7FFF;
    ticks(10);
    chk_pin(gain, 6'h10);
    chk_pin({5'h0, pk_act}, 6'h0);
    bus(1'b0, adr_stat, '0);
    chk_reg(q, 32'h00000210);
    $display("end disabled");
    // Gate and hold both want the gain frozen; the peak must still win
    rst();
    peak_cmd <= 16'h7000;
    level_cmd <= -12'sd2000;
    bus(1'b1, adr_hold, 32'hA0);
    bus(1'b1, adr_gate, 32'h8);
    bus(1'b1, adr_ctrl, ctl(0, 10));
    ticks(4);
    chk_pin({5'h0, pk_act}, 6'h0);
    chk_pin(gain, 6'h10);
    peak_cmd <= 16'h7001;
    ticks(8);
    chk_pin({5'h0, gain >= 6'h06 && gain <= 6'h09}, 6'h1);
    chk_pin({5'h0, pk_act}, 6'h1);
    ticks(20);
    chk_pin(gain, 6'h00);
    $display("end peak");
    rst();
    bus(1'b1, adr_hold, 32'h10);
    bus(1'b1, adr_ctrl, ctl(0, 10));
    ticks(hold_t(1) - 8);
    chk_pin(gain, 6'h10);
    above_cmd <= 1'b1;
    ticks(2);
    above_cmd <= 1'b0;
    ticks(hold_t(1) - 8);
    chk_pin({5'h0, gain <= 6'h10}, 6'h1);
    ticks(40);
    chk_pin({5'h0, gain > 6'h10}, 6'h1);
    $display("end hold");
    rst();
    level_cmd <= -12'sd2000;
    bus(1'b1, adr_hold, 32'h10);
    bus(1'b1, adr_gate, 32'h8);
    bus(1'b1, adr_ctrl, ctl(1, 10));
    ticks(30);
    chk_pin({5'h0, gain > 6'h10}, 6'h1);
    chk_pin({5'h0, gt_act}, 6'h0);
    rst();
    level_cmd <= -12'sd2000;
    bus(1'b1, adr_gate, 32'h0);
    bus(1'b1, adr_ctrl, ctl(0, 10));
    ticks(20);
    chk_pin({5'h0, gt_act}, 6'h0);
    chk_pin({5'h0, gain > 6'h10}, 6'h1);
    $display("end modes");
    for (int c = 0; c < 8; c++) begin
      rst();
      level_cmd <= 12'(gate_lvl(c, 16, 12) - 1);
      bus(1'b1, adr_gate, 32'h8 | c);
      bus(1'b1, adr_ctrl, ctl(0, 10));
      ticks(20);
      chk_pin({5'h0, gt_act}, 6'h1);
      chk_pin(gain, 6'h10);
      level_cmd <= 12'(gate_lvl(c, 16, 12));
      ticks(20);
      chk_pin({5'h0, gain > 6'h10}, 6'h1);
    end
    $display("end gate");
    finish_test();
  end
endmodule  // alc_hold_peak_limit_noise_gate_tb_top
